//--- iao_pkg.sv
package iao_pkg;
  localparam int unsigned IAO_DATA_W   = 8;
  localparam int unsigned IAO_ADDR_W   = 8;
  localparam logic [1:0]  IAO_OP_NONE  = 2'h0;
  localparam logic [1:0]  IAO_OP_INC   = 2'h1;
  localparam logic [1:0]  IAO_OP_INCSK = 2'h2;
  localparam logic [1:0]  IAO_OP_ORLIT = 2'h3;
  localparam logic        IAO_DEST_ACC = 1'b0;
  localparam logic        IAO_DEST_MEM = 1'b1;
  localparam logic [7:0]  IAO_ACC_RST  = 8'h00;
  localparam logic [7:0]  IAO_ZERO     = 8'h00;
  localparam logic [7:0]  IAO_ONE      = 8'h01;

  typedef enum logic [2:0] {
    IAO_ST_IDLE  = 3'b001,
    IAO_ST_READ  = 3'b010,
    IAO_ST_SKIP  = 3'b100
  } iao_state_t;
endpackage : iao_pkg

//--- iao_exec.sv
// Contract
// - Increment byte; flag 0 writes accumulator only
// - Flag 1 writes byte back, accumulator kept
// - Skip variant skips only on zero result
// - Skip discards next instruction, two cycles
// - OR literal into accumulator
`timescale 1ns/1ns
`default_nettype none
module iao_exec
  import iao_pkg::*;
(
  input  wire logic                  i_clock,
  input  wire logic                  i_rst,
  input  wire logic                  i_valid,
  input  wire logic [1:0]            i_op,
  input  wire logic                  i_dest,
  input  wire logic [IAO_ADDR_W-1:0] i_addr,
  input  wire logic [IAO_DATA_W-1:0] i_literal,
  input  wire logic [IAO_DATA_W-1:0] i_mem_rdata,
  output logic                       o_ready,
  output logic                       o_mem_rd,
  output logic                       o_mem_we,
  output logic [IAO_ADDR_W-1:0]      o_mem_addr,
  output logic [IAO_DATA_W-1:0]      o_mem_wdata,
  output logic [IAO_DATA_W-1:0]      o_acc,
  output logic                       o_zero,
  output logic                       o_discard,
  output logic                       o_done
);

  typedef struct packed {
    iao_state_t            state;
    logic                  ready;
    logic                  mem_rd;
    logic                  mem_we;
    logic [IAO_ADDR_W-1:0] mem_addr;
    logic [IAO_DATA_W-1:0] mem_wdata;
    logic [IAO_DATA_W-1:0] acc;
    logic                  zero;
    logic                  discard;
    logic                  done;
    logic                  skip_op;
    logic                  dest;
  } iao_regs_t;

  iao_regs_t             st_r;
  iao_regs_t             st_nxt;
  logic [IAO_DATA_W-1:0] sum;
  logic [IAO_DATA_W-1:0] orv;

  always_comb begin
    sum = i_mem_rdata + IAO_ONE;
    orv = st_r.acc | i_literal;
    st_nxt = st_r;
    st_nxt.mem_rd = 1'b0;
    st_nxt.mem_we = 1'b0;
    st_nxt.discard = 1'b0;
    st_nxt.done = 1'b0;
    case (st_r.state)
      IAO_ST_IDLE: begin
        if (i_valid) begin
          if (i_op == IAO_OP_INC || i_op == IAO_OP_INCSK) begin
            st_nxt.state = IAO_ST_READ;
            st_nxt.ready = 1'b0;
            st_nxt.mem_rd = 1'b1;
            st_nxt.mem_addr = i_addr;
            st_nxt.skip_op = (i_op == IAO_OP_INCSK);
            st_nxt.dest = i_dest;
          end else if (i_op == IAO_OP_ORLIT) begin
            st_nxt.acc = orv;
            st_nxt.zero = (orv == IAO_ZERO);
            st_nxt.done = 1'b1;
          end
        end
      end
      IAO_ST_READ: begin
        // Memory answers combinationally in the same cycle the read strobe is high
        if (st_r.dest == IAO_DEST_ACC) begin
          st_nxt.acc = sum;
        end else begin
          st_nxt.mem_we = 1'b1;
          st_nxt.mem_wdata = sum;
        end
        if (st_r.skip_op && sum == IAO_ZERO) begin
          st_nxt.state = IAO_ST_SKIP;
          st_nxt.discard = 1'b1;
        end else begin
          st_nxt.state = IAO_ST_IDLE;
          st_nxt.ready = 1'b1;
          st_nxt.done = 1'b1;
        end
      end
      IAO_ST_SKIP: begin
        // Extra cycle stands in for the dropped instruction
        st_nxt.state = IAO_ST_IDLE;
        st_nxt.ready = 1'b1;
        st_nxt.done = 1'b1;
      end
      default: begin
        st_nxt.state = IAO_ST_IDLE;
        st_nxt.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_r.state <= IAO_ST_IDLE;
      st_r.ready <= 1'b1;
      st_r.mem_rd <= 1'b0;
      st_r.mem_we <= 1'b0;
      st_r.mem_addr <= '0;
      st_r.mem_wdata <= '0;
      st_r.acc <= IAO_ACC_RST;
      st_r.zero <= 1'b0;
      st_r.discard <= 1'b0;
      st_r.done <= 1'b0;
      st_r.skip_op <= 1'b0;
      st_r.dest <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_ready     = st_r.ready;
  assign o_mem_rd    = st_r.mem_rd;
  assign o_mem_we    = st_r.mem_we;
  assign o_mem_addr  = st_r.mem_addr;
  assign o_mem_wdata = st_r.mem_wdata;
  assign o_acc       = st_r.acc;
  assign o_zero      = st_r.zero;
  assign o_discard   = st_r.discard;
  assign o_done      = st_r.done;

  property p_inc_acc;
    @(posedge i_clock) disable iff (i_rst)
      (st_r.state == IAO_ST_READ && st_r.dest == IAO_DEST_ACC)
        |=> (st_r.acc == $past(i_mem_rdata) + IAO_ONE) && !st_r.mem_we;
  endproperty
  a_inc_acc: assert property (p_inc_acc) else $error("increment to accumulator wrong");

  property p_inc_mem;
    @(posedge i_clock) disable iff (i_rst)
      (st_r.state == IAO_ST_READ && st_r.dest == IAO_DEST_MEM)
        |=> st_r.mem_we && st_r.mem_wdata == $past(i_mem_rdata) + IAO_ONE && $stable(st_r.acc);
  endproperty
  a_inc_mem: assert property (p_inc_mem) else $error("increment write back wrong");

  property p_skip_cond;
    @(posedge i_clock) disable iff (i_rst)
      st_r.discard |-> $past(st_r.skip_op) && $past(i_mem_rdata) == 8'hFF;
  endproperty
  a_skip_cond: assert property (p_skip_cond) else $error("skip without zero result");

  property p_skip_two;
    @(posedge i_clock) disable iff (i_rst)
      st_r.discard |-> !st_r.ready ##1 (st_r.ready && st_r.done);
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("skip not two cycles");

  property p_or_lit;
    @(posedge i_clock) disable iff (i_rst)
      (st_r.state == IAO_ST_IDLE && i_valid && i_op == IAO_OP_ORLIT)
        |=> st_r.acc == ($past(st_r.acc) | $past(i_literal)) && st_r.done;
  endproperty
  a_or_lit: assert property (p_or_lit) else $error("or literal result wrong");

  property p_or_zero;
    @(posedge i_clock) disable iff (i_rst)
      (st_r.state == IAO_ST_IDLE && i_valid && i_op == IAO_OP_ORLIT)
        |=> st_r.zero == (st_r.acc == IAO_ZERO);
  endproperty
  a_or_zero: assert property (p_or_zero) else $error("zero flag wrong");

  property p_rd_strobe;
    @(posedge i_clock) disable iff (i_rst)
      (st_r.state == IAO_ST_IDLE && i_valid && (i_op == IAO_OP_INC || i_op == IAO_OP_INCSK))
        |=> st_r.mem_rd && !st_r.ready && st_r.mem_addr == $past(i_addr);
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("increment read strobe wrong");

  property p_inc_flag_kept;
    @(posedge i_clock) disable iff (i_rst)
      (st_r.state == IAO_ST_READ)
        |=> $stable(st_r.zero);
  endproperty
  a_inc_flag_kept: assert property (p_inc_flag_kept) else $error("increment changed zero flag");

  property p_mem_dest_addr;
    @(posedge i_clock) disable iff (i_rst)
      (st_r.state == IAO_ST_READ && st_r.dest == IAO_DEST_MEM)
        |=> $stable(st_r.mem_addr);
  endproperty
  a_mem_dest_addr: assert property (p_mem_dest_addr) else $error("write back address moved");

  property p_no_skip;
    @(posedge i_clock) disable iff (i_rst)
      (st_r.state == IAO_ST_READ && !(st_r.skip_op && sum == IAO_ZERO))
        |=> st_r.done && st_r.ready && !st_r.discard && st_r.state == IAO_ST_IDLE;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("skip without cause");

  property p_skip_taken;
    @(posedge i_clock) disable iff (i_rst)
      (st_r.state == IAO_ST_READ && st_r.skip_op && sum == IAO_ZERO)
        |=> st_r.discard && !st_r.done && st_r.state == IAO_ST_SKIP;
  endproperty
  a_skip_taken: assert property (p_skip_taken) else $error("zero result did not skip");

  property p_skip_nop;
    @(posedge i_clock) disable iff (i_rst)
      (st_r.state == IAO_ST_SKIP)
        |=> !st_r.mem_rd && !st_r.mem_we && $stable(st_r.acc) && $stable(st_r.zero);
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("stall cycle changed state");

  property p_or_no_mem;
    @(posedge i_clock) disable iff (i_rst)
      (st_r.state == IAO_ST_IDLE && i_valid && i_op == IAO_OP_ORLIT)
        |=> !st_r.mem_rd && !st_r.mem_we && st_r.ready;
  endproperty
  a_or_no_mem: assert property (p_or_no_mem) else $error("or literal touched memory");

endmodule : iao_exec
`default_nettype wire

//--- iao_mem.sv
`timescale 1ns/1ns
`default_nettype none
module iao_mem
  import iao_pkg::*;
(
  input  wire logic                  i_clock,
  input  wire logic                  i_rd,
  input  wire logic                  i_we,
  input  wire logic [IAO_ADDR_W-1:0] i_addr,
  input  wire logic [IAO_DATA_W-1:0] i_wdata,
  output logic      [IAO_DATA_W-1:0] o_rdata
);
  logic [IAO_DATA_W-1:0] mem [256];
  // Unselected reads show the inverse so a stale byte never matches
  assign o_rdata = i_rd ? mem[i_addr] : ~mem[i_addr];
  always @(posedge i_clock) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end
endmodule : iao_mem
`default_nettype wire

//--- iao_exec_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module iao_exec_tb_top
  import iao_pkg::*;
;
  logic       i_clock, i_rst, i_valid, i_dest, o_ready, o_mem_rd, o_mem_we, o_zero, o_discard, o_done;
  logic [1:0] i_op;
  logic [7:0] i_addr, i_literal, i_mem_rdata, o_mem_addr, o_mem_wdata, o_acc, ea, sum, lit;
  logic [7:0] mm [4];
  logic       ez, disc, dest;
  int         failures, checks, seed, k, n, en, a, op;
  iao_exec i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_valid(i_valid), .i_op(i_op), .i_dest(i_dest),
    .i_addr(i_addr), .i_literal(i_literal), .i_mem_rdata(i_mem_rdata), .o_ready(o_ready),
    .o_mem_rd(o_mem_rd), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .o_acc(o_acc), .o_zero(o_zero), .o_discard(o_discard), .o_done(o_done));
  iao_mem i_mem (.i_clock(i_clock), .i_rd(o_mem_rd), .i_we(o_mem_we), .i_addr(o_mem_addr),
    .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
  always #5 i_clock = ~i_clock;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim;
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  initial begin
    {i_clock, i_valid, i_dest, i_op, i_addr, i_literal} = '0;
    i_rst = 1'b1;
    seed = 50416;
    ea = 8'h00;
    ez = 1'b0;
    // Bytes near the wrap point so skips happen often
    for (k = 0; k < 4; k++) begin
      mm[k] = 8'hFD + k[7:0];
      i_mem.mem[k] = mm[k];
    end
    repeat (8) @(posedge i_clock);
    #1 i_rst = 1'b0;
    for (k = 0; k < 300; k++) begin
      op = 1 + {$random(seed)} % 3;
      dest = 1'($random(seed));
      a = {$random(seed)} % 4;
      lit = ({$random(seed)} % 3 == 0) ? 8'h00 : 8'($random(seed));
      {i_valid, i_op, i_dest, i_addr, i_literal} = {1'b1, op[1:0], dest, a[7:0], lit};
      @(posedge i_clock);
      // Literal ORs go back to back, so the request stays up after them
      #1 if (op != 3) i_valid = 1'b0;
      sum = mm[a] + 8'h01;
      en = (op == 3) ? 1 : (op == 2 && sum == 8'h00) ? 3 : 2;
      if (op == 3) begin
        ea = ea | lit;
        ez = (ea == 8'h00);
      end else if (dest) mm[a] = sum;
      else ea = sum;
      n = 1;
      disc = 1'b0;
      while (o_done !== 1'b1 && n < 6) begin
        if (o_discard === 1'b1) disc = 1'b1;
        chk("ready busy", 8'h00, {7'h00, o_ready});
        @(posedge i_clock);
        #1 n++;
      end
      if (n == 6) begin
        failures++;
        end_sim();
      end
      chk("ready", 8'h01, {7'h00, o_ready});
      // Write-back lands at the edge after the write strobe
      if (op != 3) begin
        @(posedge i_clock);
        #1;
      end
      chk("cycles", en[7:0], n[7:0]);
      chk("discard", {7'h00, en == 3}, {7'h00, disc});
      chk("acc", ea, o_acc);
      chk("zero", {7'h00, ez}, {7'h00, o_zero});
      chk("mem", mm[a], i_mem.mem[a]);
    end
    end_sim();
  end
endmodule : iao_exec_tb_top
`default_nettype wire
